// ---- design/level_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock, synchronous active-high reset, clock enable.
*/
`timescale 1ns/100ps
module level_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             reset_in,
  input  wire logic             enable_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic             wr_valid_in,
  output logic                  wr_ready_out,
  output logic [WIDTH-1:0]      rd_data_out,
  output logic                  rd_valid_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]      cnt_r, cnt_nxt;
  logic             push, pop;

  assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH));
  assign rd_valid_out = (cnt_r != '0);
  assign rd_data_out  = mem_r[rp_r];

  always_comb begin
    push    = wr_valid_in && wr_ready_out;
    pop     = rd_valid_out && rd_ready_in;
    wp_nxt  = push ? ((wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1) : wp_r;
    rp_nxt  = pop  ? ((rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (enable_in) begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
      if (push) begin
        mem_r[wp_r] <= wr_data_in;
      end
    end
  end

  chk_fifo_no_over: assert property (@(posedge clock_in)
    disable iff (reset_in) cnt_r <= (AW+1)'(DEPTH))
    else $error("fifo overfilled");
endmodule

// ---- design/xcvr_mode_ctrl.sv ----
/*
  Digital mode control of a high-speed bus transceiver: standby/normal
  selection, transmit path with dominant time-out and overtemperature
  release, receive source selector with filtered wake detector, split
  termination enable. Assumes a free-running local clock; pins are
  asynchronous and synchronised here; pull-ups are modelled by the
  testbench driving a high level on undriven pins.
*/
// How it works
// - mode input high or floating selects standby.
// - normal mode receive output follows the bus level.
// - normal mode drives bus dominant while transmit input is low.
// - transmit held dominant past time-out disables the transmitter.
// - transmitter re-enabled only after a transmit rising edge.
// - overtemperature disables drivers, bus stays recessive.
// - after overtemperature, drivers wait for a transmit recessive edge.
// - standby disables drivers and receiver, wake detector only.
// - receive output selected from receiver or wake detector by mode.
// - standby receive output high until a wake-up is detected.
// - standby dominant longer than first filter drives wake flag low.
// - then recessive longer than second filter drives it high again.
// - standby entered on dominant bus needs recessive then dominant.
// - split termination enabled in normal, floating in standby.
// - floating transmit input reads recessive, never dominant.
`timescale 1ns/100ps
module xcvr_mode_ctrl
  import xcvr_pkg::*;
#(
  parameter int TIMEOUT_CYC  = DOM_TIMEOUT_CYC,
  parameter int WAKE_DOM_CYCLES = WAKE_DOM_CYC,
  parameter int WAKE_REC_CYCLES = WAKE_REC_CYC
) (
  input  wire logic clock_in,
  input  wire logic reset_in,
  input  wire logic enable_in,
  input  wire logic standby_req_in,
  input  wire logic tx_data_in,
  input  wire logic bus_level_in,
  input  wire logic overtemp_in,
  output logic      rx_data_out,
  output logic      bus_dominant_out,
  output logic      split_out,
  output logic      split_oe_out,
  output logic      normal_mode_out,
  output logic      tx_blocked_out
);
  // ==========================================================
  // pin synchronisers
  logic [1:0] stb_s_r, txd_s_r, bus_s_r, ot_s_r;
  logic       stb_q, txd_q, bus_q, ot_q;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      stb_s_r <= 2'h3;
      txd_s_r <= 2'h3;
      bus_s_r <= 2'h3;
      ot_s_r  <= 2'h0;
    end else if (enable_in) begin
      stb_s_r <= {stb_s_r[0], standby_req_in};
      txd_s_r <= {txd_s_r[0], tx_data_in};
      bus_s_r <= {bus_s_r[0], bus_level_in};
      ot_s_r  <= {ot_s_r[0], overtemp_in};
    end
  end
  assign stb_q = stb_s_r[1];
  assign txd_q = txd_s_r[1];
  assign bus_q = bus_s_r[1];
  assign ot_q  = ot_s_r[1];

  // ==========================================================
  // bus sample fifo: decouples the receiver sampling from the selector
  logic fifo_bus, fifo_vld, fifo_rdy;
  level_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_bus_fifo (
    .clock_in     (clock_in),
    .reset_in     (reset_in),
    .enable_in    (enable_in),
    .wr_data_in   (bus_q),
    .wr_valid_in  (1'b1),
    .wr_ready_out (fifo_rdy),
    .rd_data_out  (fifo_bus),
    .rd_valid_out (fifo_vld),
    .rd_ready_in  (1'b1)
  );

  // ==========================================================
  // mode
  mode_t mode_r, mode_nxt;

  always_comb begin
    mode_nxt = stb_q ? MODE_STANDBY : MODE_NORMAL;
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      mode_r <= MODE_STANDBY;
    end else if (enable_in) begin
      mode_r <= mode_nxt;
    end
  end

  // ==========================================================
  // transmit path: dominant time-out and overtemperature lock
  logic             txd_d_r, txd_d_nxt;
  logic             to_r, to_nxt;
  logic             ot_lock_r, ot_lock_nxt;
  logic [CNT_W-1:0] tx_cnt_r, tx_cnt_nxt;
  logic             txd_rise;

  always_comb begin
    txd_rise    = (txd_q == LVL_RECESSIVE) && (txd_d_r == LVL_DOMINANT);
    txd_d_nxt   = txd_q;
    to_nxt      = to_r;
    ot_lock_nxt = ot_lock_r;
    tx_cnt_nxt  = tx_cnt_r;
    // dominant time-out; counter restarts on each level change
    if (txd_q != txd_d_r || txd_q == LVL_RECESSIVE) begin
      tx_cnt_nxt = '0;
    end else if (tx_cnt_r < CNT_W'(TIMEOUT_CYC)) begin
      tx_cnt_nxt = tx_cnt_r + 1'b1;
    end
    if (tx_cnt_r >= CNT_W'(TIMEOUT_CYC)) begin
      to_nxt = 1'b1;
    end
    // the edge beats the saturated count, which drops a cycle later;
    // otherwise a stuck transmitter could never be released
    if (txd_rise) begin
      to_nxt = 1'b0;
    end
    // overtemperature lock released by a recessive edge only
    if (ot_q) begin
      ot_lock_nxt = 1'b1;
    end else if (txd_rise) begin
      ot_lock_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      txd_d_r   <= LVL_RECESSIVE;
      to_r      <= 1'b0;
      ot_lock_r <= 1'b0;
      tx_cnt_r  <= '0;
    end else if (enable_in) begin
      txd_d_r   <= txd_d_nxt;
      to_r      <= to_nxt;
      ot_lock_r <= ot_lock_nxt;
      tx_cnt_r  <= tx_cnt_nxt;
    end
  end

  // ==========================================================
  // receive path: source selector and filtered wake detector
  logic             bus_d_r, bus_d_nxt;
  logic [CNT_W-1:0] wk_cnt_r, wk_cnt_nxt;
  logic             armed_r, armed_nxt;
  logic             wake_r, wake_nxt;
  logic             rx_r, rx_nxt;
  logic             bus_now;

  always_comb begin
    // samples stall with the fifo; last seen level holds meanwhile
    bus_now    = fifo_vld ? fifo_bus : bus_d_r;
    bus_d_nxt  = bus_now;
    wk_cnt_nxt = wk_cnt_r;
    armed_nxt  = armed_r;
    wake_nxt   = wake_r;
    rx_nxt     = LVL_RECESSIVE;
    if (mode_r == MODE_NORMAL) begin
      rx_nxt     = bus_now;
      wake_nxt   = 1'b0;
      wk_cnt_nxt = '0;
      armed_nxt  = (bus_now == LVL_RECESSIVE);
      if (mode_nxt == MODE_STANDBY) begin
        rx_nxt = LVL_RECESSIVE;
      end
    end else begin
      if (bus_now != bus_d_r) begin
        wk_cnt_nxt = '0;
      end else if (wk_cnt_r < {CNT_W{1'b1}}) begin
        wk_cnt_nxt = wk_cnt_r + 1'b1;
      end
      // a dominant bus at standby entry must first go recessive
      if (bus_now == LVL_RECESSIVE) begin
        armed_nxt = 1'b1;
      end
      if (!wake_r && armed_r && bus_now == LVL_DOMINANT &&
          bus_d_r == LVL_DOMINANT &&
          wk_cnt_r >= CNT_W'(WAKE_DOM_CYCLES)) begin
        wake_nxt = 1'b1;
      end
      if (wake_r && bus_now == LVL_RECESSIVE && bus_d_r == LVL_RECESSIVE &&
          wk_cnt_r >= CNT_W'(WAKE_REC_CYCLES)) begin
        wake_nxt = 1'b0;
      end
      // wake detector feeds the output; high until a wake-up
      rx_nxt = wake_nxt ? LVL_DOMINANT : LVL_RECESSIVE;
      if (mode_nxt == MODE_NORMAL) begin
        wake_nxt   = 1'b0;
        wk_cnt_nxt = '0;
        rx_nxt     = bus_now;
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      bus_d_r  <= LVL_RECESSIVE;
      wk_cnt_r <= '0;
      armed_r  <= 1'b0;
      wake_r   <= 1'b0;
      rx_r     <= LVL_RECESSIVE;
    end else if (enable_in) begin
      bus_d_r  <= bus_d_nxt;
      wk_cnt_r <= wk_cnt_nxt;
      armed_r  <= armed_nxt;
      wake_r   <= wake_nxt;
      rx_r     <= rx_nxt;
    end
  end

  // ==========================================================
  // outputs
  logic tx_blocked;
  assign tx_blocked       = to_r || ot_lock_r || ot_q;
  assign tx_blocked_out   = tx_blocked;
  assign normal_mode_out  = (mode_r == MODE_NORMAL);
  // drivers only in normal mode, never while blocked
  assign bus_dominant_out = normal_mode_out && !tx_blocked &&
                            (txd_q == LVL_DOMINANT);
  assign rx_data_out      = rx_r;
  assign split_out        = 1'b1;
  assign split_oe_out     = normal_mode_out;

  // ==========================================================
  // checks
  chk_standby_no_drive: assert property (@(posedge clock_in)
    disable iff (reset_in) !normal_mode_out |-> !bus_dominant_out)
    else $error("driver active in standby");
  chk_mode_follow: assert property (@(posedge clock_in)
    disable iff (reset_in) enable_in && stb_q |=> !normal_mode_out)
    else $error("standby not entered");
  chk_tx_drive: assert property (@(posedge clock_in)
    disable iff (reset_in) normal_mode_out && !to_r && !ot_lock_r
    && !ot_q && txd_q == LVL_DOMINANT |-> bus_dominant_out)
    else $error("dominant not driven");
  chk_timeout_block: assert property (@(posedge clock_in)
    disable iff (reset_in) enable_in && tx_cnt_r >= CNT_W'(TIMEOUT_CYC)
    && !(txd_q && !txd_d_r) |=> tx_blocked_out)
    else $error("time-out did not block");
  chk_timeout_hold: assert property (@(posedge clock_in)
    disable iff (reset_in) to_r && txd_d_r == LVL_DOMINANT
    && txd_q == LVL_DOMINANT |=> to_r || !enable_in)
    else $error("time-out released without edge");
  chk_ot_block: assert property (@(posedge clock_in)
    disable iff (reset_in) ot_q |-> !bus_dominant_out)
    else $error("driving in overtemperature");
  chk_ot_release: assert property (@(posedge clock_in)
    disable iff (reset_in) ot_lock_r && !ot_q && enable_in
    && !(txd_q && !txd_d_r) |=> ot_lock_r)
    else $error("overtemperature lock dropped early");
  chk_split_mode: assert property (@(posedge clock_in)
    disable iff (reset_in) enable_in |=> split_oe_out == !$past(stb_q))
    else $error("split enable wrong");
  chk_standby_rx_high: assert property (@(posedge clock_in)
    disable iff (reset_in) !normal_mode_out && !wake_r
    && $past(!normal_mode_out) |-> rx_data_out)
    else $error("standby output low without wake");
  chk_standby_route: assert property (@(posedge clock_in)
    disable iff (reset_in) !normal_mode_out && $past(!normal_mode_out)
    && $past(enable_in)
    |-> rx_data_out == (wake_r ? LVL_DOMINANT : LVL_RECESSIVE))
    else $error("standby output not from wake detector");
  chk_normal_rx: assert property (@(posedge clock_in)
    disable iff (reset_in) normal_mode_out && enable_in && stb_q == 1'b0
    |=> rx_data_out == $past(bus_now) || !enable_in)
    else $error("receive output not following bus");
  chk_wake_filter: assert property (@(posedge clock_in)
    disable iff (reset_in) !wake_r ##1 wake_r |-> $past(
    bus_now == LVL_DOMINANT && wk_cnt_r >= CNT_W'(WAKE_DOM_CYCLES)))
    else $error("wake flag set before dominant filter");
  chk_wake_armed: assert property (@(posedge clock_in)
    disable iff (reset_in) !wake_r ##1 wake_r |-> $past(armed_r))
    else $error("wake flag set without recessive first");
  chk_wake_release: assert property (@(posedge clock_in)
    disable iff (reset_in) wake_r ##1 !wake_r && !normal_mode_out
    |-> $past(bus_now == LVL_RECESSIVE
    && wk_cnt_r >= CNT_W'(WAKE_REC_CYCLES)))
    else $error("wake flag cleared before recessive filter");
  chk_wake_clear: assert property (@(posedge clock_in)
    disable iff (reset_in) normal_mode_out |-> !wake_r)
    else $error("wake state kept in normal");
  chk_fifo_room: assert property (@(posedge clock_in)
    disable iff (reset_in) fifo_rdy)
    else $error("bus sample fifo full");

  cov_wake: cover property (@(posedge clock_in) $rose(wake_r));
  cov_wake_end: cover property (@(posedge clock_in) $fell(wake_r));
  cov_timeout: cover property (@(posedge clock_in) $rose(to_r));
  cov_ot: cover property (@(posedge clock_in) $fell(ot_lock_r));
  cov_normal: cover property (@(posedge clock_in) $rose(normal_mode_out));
endmodule

// ---- design/xcvr_pkg.sv ----
/*
  Constants shared by the transceiver mode-control logic: filter and
  time-out durations, their cycle counts at the local clock, pin levels.
  Assumes a single 50 MHz local clock.
*/
package xcvr_pkg;
  // ==========================================================
  // clock
  localparam int CLK_PERIOD_NS = 20;
  // ==========================================================
  // timing (time in its own unit, then cycles)
  localparam int DOM_TIMEOUT_US    = 1000;
  localparam int DOM_TIMEOUT_CYC   = DOM_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int WAKE_DOM_NS       = 500;
  localparam int WAKE_DOM_CYC      = WAKE_DOM_NS / CLK_PERIOD_NS;
  localparam int WAKE_REC_NS       = 500;
  localparam int WAKE_REC_CYC      = WAKE_REC_NS / CLK_PERIOD_NS;
  localparam int CNT_W             = 24;
  // ==========================================================
  // levels
  localparam logic LVL_DOMINANT  = 1'b0;
  localparam logic LVL_RECESSIVE = 1'b1;
  // ==========================================================
  // fifo
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_WIDTH = 1;
  typedef enum logic {MODE_STANDBY, MODE_NORMAL} mode_t;
endpackage

// ---- verif/ctrl_bus_model.sv ----
/*
  Controller and bus model facing the transceiver control logic.
  Assumes tri1 nets at the tb for mode and transmit pins (pull-ups).
*/
`timescale 1ns/100ps
module ctrl_bus_model (
  input  wire logic stb_en_in,
  input  wire logic stb_lvl_in,
  input  wire logic tx_en_in,
  input  wire logic tx_lvl_in,
  input  wire logic remote_dom_in,
  input  wire logic bus_dominant_in,
  output wire       stb_pin_out,
  output wire       tx_pin_out,
  output logic      bus_level_out
);
  // ==========================================================
  // pins: released pins float, the tb net pull-up decides
  assign stb_pin_out = stb_en_in ? stb_lvl_in : 1'bz;
  assign tx_pin_out  = tx_en_in ? tx_lvl_in : 1'bz;
  // ==========================================================
  // bus: wired-and, any driver dominant pulls it low
  assign bus_level_out = (bus_dominant_in | remote_dom_in) ? 1'b0 : 1'b1;
endmodule

// ---- verif/tb_top.sv ----
/*
  Self-checking bench of the transceiver mode control.
  Assumes 50 MHz clock, short time-out and wake filter parameters.
*/
`timescale 1ns/100ps
module tb_top;
  import xcvr_pkg::*;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic enable_in = 1'b1;
  logic ot = 1'b0;
  logic stb_en = 1'b0, stb_lvl = 1'b1, tx_en = 1'b0, tx_lvl = 1'b1;
  logic rem = 1'b0;
  tri1  stb_w, tx_w;
  logic bus_w, rx, dom, split, split_oe, normal, blocked;
  int   errors = 0, checks_done = 0, cycles = 0, run, i;

  always #10 clock_in = ~clock_in;

  ctrl_bus_model u_ctrl_bus_model (
    .stb_en_in(stb_en), .stb_lvl_in(stb_lvl), .tx_en_in(tx_en),
    .tx_lvl_in(tx_lvl), .remote_dom_in(rem), .bus_dominant_in(dom),
    .stb_pin_out(stb_w), .tx_pin_out(tx_w), .bus_level_out(bus_w));

  xcvr_mode_ctrl #(.TIMEOUT_CYC(50), .WAKE_DOM_CYCLES(5),
                   .WAKE_REC_CYCLES(5)) u_xcvr_mode_ctrl (
    .clock_in(clock_in), .reset_in(reset_in), .enable_in(enable_in),
    .standby_req_in(stb_w), .tx_data_in(tx_w), .bus_level_in(bus_w),
    .overtemp_in(ot), .rx_data_out(rx), .bus_dominant_out(dom),
    .split_out(split), .split_oe_out(split_oe),
    .normal_mode_out(normal), .tx_blocked_out(blocked));

  // ==========================================================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask

  task automatic check(input logic seen, input logic exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask

  function automatic logic exp_dom(input logic t);
    return t == LVL_DOMINANT;
  endfunction

  function automatic logic exp_rx(input logic t, input logic r);
    return (exp_dom(t) | r) ? LVL_DOMINANT : LVL_RECESSIVE;
  endfunction

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ceiling well above the roughly 600 cycles the tests need
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    void'($urandom(32'hf90cce33));
    cyc(5);
    reset_in = 1'b0;
    // both pins floating: pull-ups keep standby and recessive
    cyc(8);
    check(normal, 1'b0);
    check(dom, 1'b0);
    check(split_oe, 1'b0);
    check(rx, 1'b1);
    tx_en = 1'b1;
    tx_lvl = 1'b0;
    cyc(8);
    check(dom, 1'b0);
    tx_lvl = 1'b1;
    // frozen clock enable holds the mode
    enable_in = 1'b0;
    stb_en = 1'b1;
    stb_lvl = 1'b0;
    cyc(8);
    check(normal, 1'b0);
    enable_in = 1'b1;
    cyc(8);
    check(normal, 1'b1);
    check(split_oe, 1'b1);
    check(split, 1'b1);
    // random traffic, dominant runs kept short of the time-out
    run = 0;
    for (i = 0; i < 40; i++) begin
      tx_lvl = 1'($urandom % 2);
      rem = ($urandom % 4) == 0;
      run = tx_lvl ? 0 : run + 1;
      if (run == 4) begin
        tx_lvl = 1'b1;
        run = 0;
      end
      cyc(8);
      check(dom, exp_dom(tx_lvl));
      check(rx, exp_rx(tx_lvl, rem));
    end
    tx_lvl = 1'b1;
    rem = 1'b0;
    cyc(8);
    // stuck dominant transmit
    tx_lvl = 1'b0;
    cyc(40);
    check(dom, 1'b1);
    cyc(22);
    check(dom, 1'b0);
    check(blocked, 1'b1);
    tx_lvl = 1'b1;
    cyc(8);
    check(blocked, 1'b0);
    tx_lvl = 1'b0;
    cyc(6);
    check(dom, 1'b1);
    // overtemperature in mid-bit, release on recessive edge
    ot = 1'b1;
    cyc(6);
    check(dom, 1'b0);
    check(blocked, 1'b1);
    ot = 1'b0;
    cyc(8);
    check(dom, 1'b0);
    tx_lvl = 1'b1;
    cyc(6);
    tx_lvl = 1'b0;
    cyc(6);
    check(dom, 1'b1);
    tx_lvl = 1'b1;
    cyc(6);
    // standby entered on a stuck dominant bus
    rem = 1'b1;
    cyc(6);
    stb_lvl = 1'b1;
    cyc(14);
    check(normal, 1'b0);
    check(rx, 1'b1);
    rem = 1'b0;
    cyc(10);
    rem = 1'b1;
    cyc(14);
    check(rx, 1'b0);
    rem = 1'b0;
    cyc(14);
    check(rx, 1'b1);
    // glitch shorter than the dominant filter
    rem = 1'b1;
    cyc(3);
    rem = 1'b0;
    cyc(10);
    check(rx, 1'b1);
    rem = 1'b1;
    cyc(14);
    check(rx, 1'b0);
    // controller sees the wake flag and returns to normal
    stb_lvl = 1'b0;
    rem = 1'b0;
    cyc(10);
    check(normal, 1'b1);
    check(rx, 1'b1);
    rem = 1'b1;
    cyc(8);
    check(rx, 1'b0);
    rem = 1'b0;
    cyc(8);
    // reset in mid-run while transmitting: back to fail-safe standby
    tx_lvl = 1'b0;
    cyc(4);
    check(dom, 1'b1);
    reset_in = 1'b1;
    cyc(2);
    check(normal, 1'b0);
    check(dom, 1'b0);
    check(split_oe, 1'b0);
    check(rx, 1'b1);
    reset_in = 1'b0;
    cyc(8);
    check(normal, 1'b1);
    check(dom, 1'b1);
    tx_lvl = 1'b1;
    cyc(8);
    end_of_test();
  end
endmodule
